// file: rtl/modbus_write_regs.sv
`timescale 1ns/100ps
`include "mb_map.svh"
module modbus_write_regs
    import mb_pkg::*;
#(
    // arbitrary value
    parameter logic [15:0] FW_VERSION = 16'h0064
)
(
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic [7:0] STATION_NUMBER,
    input wire rx_s RX,
    output logic RX_READY,
    output tx_s TX,
    input wire logic TX_READY,
    input wire logic [7:0] DIGITAL_IN,
    input wire logic COMM_TIMEOUT,
    input wire logic [1:0] PAIR_STATUS,
    output logic [7:0] COIL_OUT,
    output logic RESTORE_WEB_DEFAULTS,
    output logic RESTORE_ID_DEFAULTS,
    output logic REBOOT_REQUEST,
    output logic [`HOLD_WORDS*16-1:0] HOLD_REGS,
    output logic [31:0] HOLD_LONG0
);
    typedef struct packed {
        ctl_e st;
        logic [15:0] idx;
        req_s req;
        logic [7:0] hi;
        logic wr_ok;
        logic [7:0] exc;
        logic [15:0] tx_idx;
        logic [15:0] tx_len;
        tx_s tx;
    } top_s;

    top_s s_q;
    top_s s_d;
    wr_s wr;
    wr_s cw;
    word_t bank_rd;
    word_t rd_addr;
    word_t rd_word;
    logic [15:0] data_j;
    logic [15:0] tx_j;
    logic [15:0] plen;
    logic [7:0] tx_byte;
    logic [7:0] bit_src;
    logic [7:0] b;

    function automatic logic station_ok(logic [7:0] st, logic [7:0] own);
        station_ok = (st >= `STATION_MIN) && (st <= `STATION_MAX) && (st == own);
    endfunction

    function automatic logic hold_range_ok(word_t addr, word_t cnt);
        logic [16:0] top;
        top = {1'b0, addr} + {1'b0, cnt};
        hold_range_ok = (cnt != 16'h0000) && (addr >= `HOLD_BASE)
            && (top <= ({1'b0, `HOLD_BASE} + `HOLD_SPAN));
    endfunction

    function automatic logic ir_ok(word_t addr);
        ir_ok = (addr == `IR_FW) || (addr == `IR_COMM) || (addr == `IR_PAIR);
    endfunction

    function automatic word_t ir_word(word_t addr, logic comm, logic [1:0] pair);
        ir_word = 16'h0000;
        if (addr == `IR_FW)
        begin
            ir_word = FW_VERSION;
        end
        else if (addr == `IR_COMM)
        begin
            ir_word = {15'h0000, comm};
        end
        else if (addr == `IR_PAIR)
        begin
            ir_word = {14'h0000, pair};
        end
    endfunction

    function automatic logic cnt_ok(word_t cnt, word_t most);
        cnt_ok = (cnt != 16'h0000) && (cnt <= most);
    endfunction

    function automatic logic [7:0] check_req(req_s r);
        logic [7:0] e;
        logic [16:0] top;
        int i;
        e = `EXC_NONE;
        top = {1'b0, r.addr} + {1'b0, r.cnt};
        case (r.fc)
            `FC_RD_COILS, `FC_RD_DISC:
            begin
                if (r.len < `PDU_FIXED || !cnt_ok(r.cnt, `MAX_READ))
                begin
                    e = `EXC_VALUE;
                end
                else if (top > `DO_COILS)
                begin
                    e = `EXC_ADDR;
                end
            end
            `FC_RD_HOLD:
            begin
                if (r.len < `PDU_FIXED || !cnt_ok(r.cnt, `MAX_READ))
                begin
                    e = `EXC_VALUE;
                end
                else if (!hold_range_ok(r.addr, r.cnt))
                begin
                    e = `EXC_ADDR;
                end
            end
            `FC_RD_INPUT:
            begin
                if (r.len < `PDU_FIXED || !cnt_ok(r.cnt, `MAX_READ))
                begin
                    e = `EXC_VALUE;
                end
                else
                begin
                    // sparse space: every word of the range must exist
                    for (i = 0; i < 8; i++)
                    begin
                        if (16'(i) < r.cnt && !ir_ok(r.addr + 16'(i)))
                        begin
                            e = `EXC_ADDR;
                        end
                    end
                end
            end
            `FC_WR_COIL:
            begin
                if (r.len < `PDU_FIXED || (r.cnt != `COIL_ON && r.cnt != `COIL_OFF))
                begin
                    e = `EXC_VALUE;
                end
                else if (!({1'b0, r.addr} < `DO_COILS || r.addr == `COIL_WEB
                    || r.addr == `COIL_ID || r.addr == `COIL_REBOOT))
                begin
                    e = `EXC_ADDR;
                end
            end
            `FC_WR_MULTI:
            begin
                if (r.len < `PDU_MULTI_MIN || !cnt_ok(r.cnt, `MAX_WRITE)
                    || {r.cnt[14:0], 1'b0} != {8'h00, r.bc}
                    || r.len != `PDU_MULTI_MIN + {8'h00, r.bc})
                begin
                    e = `EXC_VALUE;
                end
                else if (!hold_range_ok(r.addr, r.cnt))
                begin
                    e = `EXC_ADDR;
                end
            end
            default:
            begin
                e = `EXC_FUNC;
            end
        endcase
        check_req = e;
    endfunction

    function automatic logic [15:0] pdu_len(req_s r, logic [7:0] e);
        pdu_len = `PDU_ECHO;
        if (e != `EXC_NONE)
        begin
            pdu_len = `PDU_EXC;
        end
        else if (r.fc == `FC_RD_COILS || r.fc == `FC_RD_DISC)
        begin
            pdu_len = `PDU_EXC + 16'h0001;
        end
        else if (r.fc == `FC_RD_HOLD || r.fc == `FC_RD_INPUT)
        begin
            pdu_len = `PDU_EXC + {r.cnt[14:0], 1'b0};
        end
    endfunction

    assign b = RX.data;
    assign data_j = s_q.idx - `IDX_DATA;
    assign tx_j = s_q.tx_idx - `IDX_ADDR_LO;
    assign plen = s_q.tx_len - `MBAP_BYTES;
    assign rd_addr = s_q.req.addr + {1'b0, tx_j[15:1]};
    assign rd_word = (s_q.req.fc == `FC_RD_HOLD) ? bank_rd
        : ir_word(rd_addr, COMM_TIMEOUT, PAIR_STATUS);
    assign bit_src = (s_q.req.fc == `FC_RD_COILS) ? COIL_OUT : DIGITAL_IN;

    // receive, judge, answer
    always_comb
    begin
        s_d = s_q;
        wr = '0;
        cw = '0;
        case (s_q.st)
            ST_RX:
            begin
                if (RX.valid)
                begin
                    s_d.idx = s_q.idx + 16'h0001;
                    if (s_q.idx == 16'h0000)
                    begin
                        s_d.req = '0;
                        s_d.wr_ok = 1'b0;
                        s_d.req.msg = {24'h000000, b};
                    end
                    else if (s_q.idx < `IDX_LEN_HI)
                    begin
                        s_d.req.msg = {s_q.req.msg[23:0], b};
                    end
                    else if (s_q.idx == `IDX_LEN_HI)
                    begin
                        s_d.req.len[15:8] = b;
                    end
                    else if (s_q.idx == `IDX_LEN_LO)
                    begin
                        s_d.req.len[7:0] = b;
                    end
                    else if (s_q.idx == `IDX_STATION)
                    begin
                        s_d.req.station = b;
                    end
                    else if (s_q.idx == `IDX_FC)
                    begin
                        s_d.req.fc = b;
                    end
                    else if (s_q.idx == `IDX_ADDR_HI)
                    begin
                        s_d.req.addr[15:8] = b;
                    end
                    else if (s_q.idx == `IDX_ADDR_LO)
                    begin
                        s_d.req.addr[7:0] = b;
                    end
                    else if (s_q.idx == `IDX_CNT_HI)
                    begin
                        s_d.req.cnt[15:8] = b;
                    end
                    else if (s_q.idx == `IDX_CNT_LO)
                    begin
                        s_d.req.cnt[7:0] = b;
                    end
                    else if (s_q.idx == `IDX_BC)
                    begin
                        s_d.req.bc = b;
                        // words are stored as they arrive, so the header is vetted first
                        s_d.wr_ok = (s_q.req.fc == `FC_WR_MULTI)
                            && station_ok(s_q.req.station, STATION_NUMBER)
                            && hold_range_ok(s_q.req.addr, s_q.req.cnt)
                            && {s_q.req.cnt[14:0], 1'b0} == {8'h00, b};
                    end
                    else if (s_q.wr_ok && data_j < {8'h00, s_q.req.bc})
                    begin
                        if (!data_j[0])
                        begin
                            s_d.hi = b;
                        end
                        else
                        begin
                            wr.we = 1'b1;
                            wr.addr = s_q.req.addr + {1'b0, data_j[15:1]};
                            wr.data = {s_q.hi, b};
                        end
                    end
                    if (s_q.idx == `IDX_LEN_LO && {s_q.req.len[15:8], b} == 16'h0000)
                    begin
                        s_d.idx = 16'h0000;
                    end
                    else if (s_q.idx >= `IDX_STATION
                        && s_q.idx == s_q.req.len + `IDX_LEN_LO)
                    begin
                        s_d.st = ST_EVAL;
                    end
                end
            end
            ST_EVAL:
            begin
                s_d.exc = check_req(s_q.req);
                s_d.tx_len = `MBAP_BYTES + pdu_len(s_q.req, s_d.exc);
                s_d.tx_idx = 16'h0000;
                s_d.idx = 16'h0000;
                if (!station_ok(s_q.req.station, STATION_NUMBER))
                begin
                    s_d.st = ST_RX;
                end
                else
                begin
                    s_d.st = ST_TX;
                    if (s_q.req.fc == `FC_WR_COIL && s_d.exc == `EXC_NONE)
                    begin
                        cw.we = 1'b1;
                        cw.addr = s_q.req.addr;
                        cw.data = s_q.req.cnt;
                    end
                end
            end
            ST_TX:
            begin
                if (!s_q.tx.valid || TX_READY)
                begin
                    if (s_q.tx_idx < s_q.tx_len)
                    begin
                        s_d.tx.valid = 1'b1;
                        s_d.tx.last = (s_q.tx_idx == s_q.tx_len - 16'h0001);
                        s_d.tx.data = tx_byte;
                        s_d.tx_idx = s_q.tx_idx + 16'h0001;
                    end
                    else
                    begin
                        s_d.tx = '0;
                        s_d.st = ST_RX;
                    end
                end
            end
            default:
            begin
                s_d.st = ST_RX;
            end
        endcase
    end

    // byte of the answer at the current send position
    always_comb
    begin
        tx_byte = 8'h00;
        case (s_q.tx_idx)
            16'h0000: tx_byte = s_q.req.msg[31:24];
            16'h0001: tx_byte = s_q.req.msg[23:16];
            16'h0002: tx_byte = s_q.req.msg[15:8];
            16'h0003: tx_byte = s_q.req.msg[7:0];
            `IDX_LEN_HI: tx_byte = plen[15:8];
            `IDX_LEN_LO: tx_byte = plen[7:0];
            `IDX_STATION: tx_byte = s_q.req.station;
            `IDX_FC:
            begin
                tx_byte = (s_q.exc != `EXC_NONE) ? (s_q.req.fc | `FC_EXC_FLAG)
                    : s_q.req.fc;
            end
            default:
            begin
                if (s_q.exc != `EXC_NONE)
                begin
                    tx_byte = s_q.exc;
                end
                else if (s_q.req.fc == `FC_RD_COILS || s_q.req.fc == `FC_RD_DISC)
                begin
                    // one byte covers at most eight points
                    tx_byte = (s_q.tx_idx == `IDX_ADDR_HI) ? 8'h01
                        : (bit_src >> s_q.req.addr[2:0])
                        & (8'hff >> (4'h8 - s_q.req.cnt[3:0]));
                end
                else if (s_q.req.fc == `FC_RD_HOLD || s_q.req.fc == `FC_RD_INPUT)
                begin
                    if (s_q.tx_idx == `IDX_ADDR_HI)
                    begin
                        tx_byte = {s_q.req.cnt[6:0], 1'b0};
                    end
                    else
                    begin
                        tx_byte = tx_j[0] ? rd_word[7:0] : rd_word[15:8];
                    end
                end
                else
                begin
                    case (s_q.tx_idx)
                        `IDX_ADDR_HI: tx_byte = s_q.req.addr[15:8];
                        `IDX_ADDR_LO: tx_byte = s_q.req.addr[7:0];
                        `IDX_CNT_HI: tx_byte = s_q.req.cnt[15:8];
                        default: tx_byte = s_q.req.cnt[7:0];
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s_q <= '{st: ST_RX, default: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    hold_bank u_bank (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .wr(wr),
        .rd_addr(rd_addr),
        .rd_data(bank_rd),
        .all_words(HOLD_REGS)
    );

    coil_pulses u_coils (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .cw(cw),
        .coils(COIL_OUT),
        .web_pulse(RESTORE_WEB_DEFAULTS),
        .id_pulse(RESTORE_ID_DEFAULTS),
        .reboot_pulse(REBOOT_REQUEST)
    );

    assign RX_READY = (s_q.st == ST_RX);
    assign TX = s_q.tx;
    assign HOLD_LONG0 = {HOLD_REGS[31:16], HOLD_REGS[15:0]};
endmodule // modbus_write_regs

// file: rtl/mb_map.svh
`ifndef MB_MAP_SVH
`define MB_MAP_SVH
`define FC_RD_COILS 8'h01
`define FC_RD_DISC 8'h02
`define FC_RD_HOLD 8'h03
`define FC_RD_INPUT 8'h04
`define FC_WR_COIL 8'h05
`define FC_WR_MULTI 8'h10
`define FC_EXC_FLAG 8'h80
`define EXC_NONE 8'h00
`define EXC_FUNC 8'h01
`define EXC_ADDR 8'h02
`define EXC_VALUE 8'h03
`define STATION_MIN 8'h01
`define STATION_MAX 8'hf7
`define IDX_LEN_HI 16'h0004
`define IDX_LEN_LO 16'h0005
`define IDX_STATION 16'h0006
`define IDX_FC 16'h0007
`define IDX_ADDR_HI 16'h0008
`define IDX_ADDR_LO 16'h0009
`define IDX_CNT_HI 16'h000a
`define IDX_CNT_LO 16'h000b
`define IDX_BC 16'h000c
`define IDX_DATA 16'h000d
`define MBAP_BYTES 16'h0006
`define PDU_FIXED 16'h0006
`define PDU_MULTI_MIN 16'h0007
`define PDU_EXC 16'h0003
`define PDU_ECHO 16'h0006
`define MAX_READ 16'h0008
`define MAX_WRITE 16'h007b
`define COIL_ON 16'hff00
`define COIL_OFF 16'h0000
`define DO_COILS 17'h00008
`define COIL_WEB 16'h007f
`define COIL_ID 16'h0080
`define COIL_REBOOT 16'h0085
`define IR_FW 16'h0097
`define IR_COMM 16'h009e
`define IR_PAIR 16'h00a0
`define HOLD_BASE 16'h0100
`define HOLD_WORDS 16
`define HOLD_SPAN 17'h00010
`define COILS_RESET 8'h00
`define HOLD_RESET 16'h0000
`endif

// file: rtl/mb_pkg.sv
package mb_pkg;
    typedef enum logic [1:0] {ST_RX, ST_EVAL, ST_TX} ctl_e;
    typedef logic [15:0] word_t;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rx_s;
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } tx_s;
    typedef struct packed {
        logic [31:0] msg;
        logic [15:0] len;
        logic [7:0] station;
        logic [7:0] fc;
        logic [15:0] addr;
        logic [15:0] cnt;
        logic [7:0] bc;
    } req_s;
    typedef struct packed {
        logic we;
        word_t addr;
        word_t data;
    } wr_s;
endpackage

// file: rtl/hold_bank.sv
`timescale 1ns/100ps
`include "mb_map.svh"
module hold_bank
    import mb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire wr_s wr,
    input wire word_t rd_addr,
    output word_t rd_data,
    output logic [`HOLD_WORDS*16-1:0] all_words
);
    typedef struct packed {
        logic [`HOLD_WORDS-1:0][15:0] mem;
    } bank_s;
    bank_s s_q;
    bank_s s_d;
    word_t wr_off;
    word_t rd_off;

    assign wr_off = wr.addr - `HOLD_BASE;
    assign rd_off = rd_addr - `HOLD_BASE;

    always_comb
    begin
        s_d = s_q;
        if (wr.we)
        begin
            s_d.mem[wr_off[3:0]] = wr.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= {`HOLD_WORDS{`HOLD_RESET}};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.mem[rd_off[3:0]];
    assign all_words = s_q.mem;
endmodule // hold_bank

// file: rtl/coil_pulses.sv
`timescale 1ns/100ps
`include "mb_map.svh"
module coil_pulses
    import mb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire wr_s cw,
    output logic [7:0] coils,
    output logic web_pulse,
    output logic id_pulse,
    output logic reboot_pulse
);
    typedef struct packed {
        logic [7:0] coils;
        logic web;
        logic id;
        logic reboot;
    } coil_s;
    coil_s s_q;
    coil_s s_d;
    logic on;

    assign on = (cw.data == `COIL_ON);

    always_comb
    begin
        s_d = s_q;
        // pulses last one clock whatever the master writes next
        s_d.web = 1'b0;
        s_d.id = 1'b0;
        s_d.reboot = 1'b0;
        if (cw.we)
        begin
            if ({1'b0, cw.addr} < `DO_COILS)
            begin
                s_d.coils[cw.addr[2:0]] = on;
            end
            s_d.web = on && (cw.addr == `COIL_WEB);
            s_d.id = on && (cw.addr == `COIL_ID);
            s_d.reboot = on && (cw.addr == `COIL_REBOOT);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= {`COILS_RESET, 3'b000};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign coils = s_q.coils;
    assign web_pulse = s_q.web;
    assign id_pulse = s_q.id;
    assign reboot_pulse = s_q.reboot;
endmodule // coil_pulses

// file: sim/modbus_write_regs_props.sv
`timescale 1ns/100ps
`include "mb_map.svh"
module modbus_write_regs_props
    import mb_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire rx_s RX,
    input wire logic RX_READY,
    input wire tx_s TX,
    input wire logic TX_READY,
    input wire logic RESTORE_WEB_DEFAULTS,
    input wire logic RESTORE_ID_DEFAULTS,
    input wire logic REBOOT_REQUEST,
    input wire logic [`HOLD_WORDS*16-1:0] HOLD_REGS,
    input wire logic [31:0] HOLD_LONG0
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    logic any_pulse;
    assign any_pulse = RESTORE_WEB_DEFAULTS | RESTORE_ID_DEFAULTS | REBOOT_REQUEST;
    a_web_once: assert property (RESTORE_WEB_DEFAULTS |=> !RESTORE_WEB_DEFAULTS)
        else $error("web restore pulse too long");
    a_id_once: assert property (RESTORE_ID_DEFAULTS |=> !RESTORE_ID_DEFAULTS)
        else $error("id restore pulse too long");
    a_boot_once: assert property (REBOOT_REQUEST |=> !REBOOT_REQUEST)
        else $error("reboot pulse too long");
    a_pulse_alone: assert property ($onehot0({RESTORE_WEB_DEFAULTS, RESTORE_ID_DEFAULTS,
        REBOOT_REQUEST}))
        else $error("two coil pulses at once");
    // pulses come only from an evaluated frame, never while idle
    a_pulse_busy: assert property (any_pulse |-> !RX_READY)
        else $error("coil pulse while receiving");
    a_tx_stands: assert property (TX.valid && !TX_READY |=>
        TX.valid && $stable(TX.data) && $stable(TX.last))
        else $error("answer byte changed before taken");
    a_last_ends: assert property (TX.valid && TX.last && TX_READY |=> !TX.valid)
        else $error("answer runs past last byte");
    a_one_frame: assert property (TX.valid |-> !RX_READY)
        else $error("receiving while answering");
    a_long_pair: assert property (HOLD_LONG0 == HOLD_REGS[31:0])
        else $error("long value not low word first");
    a_hold_cause: assert property ($changed(HOLD_REGS) |->
        $past(RX.valid && RX_READY) || $past(RX.valid && RX_READY, 2))
        else $error("holding word changed without data");
endmodule // modbus_write_regs_props
bind modbus_write_regs modbus_write_regs_props props_u (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
    .RX(RX), .RX_READY(RX_READY), .TX(TX), .TX_READY(TX_READY),
    .RESTORE_WEB_DEFAULTS(RESTORE_WEB_DEFAULTS), .RESTORE_ID_DEFAULTS(RESTORE_ID_DEFAULTS),
    .REBOOT_REQUEST(REBOOT_REQUEST), .HOLD_REGS(HOLD_REGS), .HOLD_LONG0(HOLD_LONG0));

// file: sim/mb_master.sv
`timescale 1ns/100ps
module mb_master
    import mb_pkg::*;
(
    input wire logic clk,
    input wire logic rx_ready,
    input wire tx_s tx,
    output rx_s rx,
    output logic tx_ready
);
    logic [7:0] q[$];
    logic [7:0] rsp[$];
    logic slow = 1'b0;
    logic done = 1'b0;
    initial rx = '{valid: 1'b0, data: 8'h00};
    initial tx_ready = 1'b1;
    // bytes go out in queue order, each held until taken
    task automatic send();
        logic t;
        int n;
        n = 0;
        while (q.size() > 0 && n < 500)
        begin
            @(negedge clk);
            rx.valid = 1'b1;
            rx.data = q[0];
            t = rx_ready;
            @(posedge clk);
            if (t)
                void'(q.pop_front());
            n++;
        end
        @(negedge clk);
        rx.valid = 1'b0;
        // released data shows no stale value
        rx.data = ~rx.data;
    endtask
    always @(negedge clk)
        tx_ready <= slow ? ~tx_ready : 1'b1;
    always @(posedge clk)
    begin
        if (tx.valid && tx_ready)
        begin
            rsp.push_back(tx.data);
            if (tx.last)
                done <= 1'b1;
        end
    end
endmodule // mb_master

// file: sim/modbus_tcp_write_regs_and_common_map_tb_top.sv
`timescale 1ns/100ps
`include "mb_map.svh"
module modbus_tcp_write_regs_and_common_map_tb_top;
    import mb_pkg::*;
    localparam logic [15:0] FW = 16'h007b;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] din = 8'h5a;
    logic comm_to = 1'b0;
    logic [1:0] pair = 2'h0;
    rx_s rx;
    tx_s tx;
    logic rx_ready, tx_ready, web, idd, boot;
    logic [7:0] coils;
    logic [`HOLD_WORDS*16-1:0] hold;
    logic [31:0] long0;
    int n_errors = 0;
    int samples_checked = 0;
    int n_web = 0, n_id = 0, n_boot = 0, msg = 0;
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        n_web <= n_web + int'(web);
        n_id <= n_id + int'(idd);
        n_boot <= n_boot + int'(boot);
    end
    modbus_write_regs #(.FW_VERSION(FW)) dut_u (.SYS_CLK(sys_clk), .RESETN(resetn),
        .STATION_NUMBER(8'h01), .RX(rx), .RX_READY(rx_ready), .TX(tx), .TX_READY(tx_ready),
        .DIGITAL_IN(din), .COMM_TIMEOUT(comm_to), .PAIR_STATUS(pair), .COIL_OUT(coils),
        .RESTORE_WEB_DEFAULTS(web), .RESTORE_ID_DEFAULTS(idd), .REBOOT_REQUEST(boot),
        .HOLD_REGS(hold), .HOLD_LONG0(long0));
    mb_master m_u (.clk(sys_clk), .rx_ready(rx_ready), .tx(tx), .rx(rx), .tx_ready(tx_ready));
    task automatic complete_run();
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask
    // prefix built here so every frame sent through xact carries a fresh message number
    task automatic xact(input logic [7:0] req[$], input logic [7:0] exp[$]);
        int i;
        msg++;
        m_u.q = {msg[31:24], msg[23:16], msg[15:8], msg[7:0], 8'h00, 8'(req.size()), req};
        m_u.rsp = {};
        m_u.done = 1'b0;
        m_u.send();
        check("rx_left", 0, m_u.q.size());
        for (i = 0; i < 400 && !m_u.done; i++)
            @(posedge sys_clk);
        if (!m_u.done)
        begin
            n_errors++;
            complete_run();
        end
        exp = {msg[31:24], msg[23:16], msg[15:8], msg[7:0], 8'h00, 8'(exp.size()), exp};
        check("rsp_len", exp.size(), m_u.rsp.size());
        for (i = 0; i < exp.size() && i < m_u.rsp.size(); i++)
            check("rsp_byte", exp[i], m_u.rsp[i]);
    endtask
    task automatic t_write();
        m_u.slow = 1'b1;
        xact({8'h01, 8'h10, 8'h01, 8'h00, 8'h00, 8'h02, 8'h04, 8'h0c, 8'h0d, 8'h0a, 8'h0b},
            {8'h01, 8'h10, 8'h01, 8'h00, 8'h00, 8'h02});
        m_u.slow = 1'b0;
        check("hold_w0", 32'h0c0d, hold[15:0]);
        check("long0", 32'h0a0b0c0d, long0);
        xact({8'h01, 8'h03, 8'h01, 8'h00, 8'h00, 8'h02},
            {8'h01, 8'h03, 8'h04, 8'h0c, 8'h0d, 8'h0a, 8'h0b});
    endtask
    task automatic t_errors();
        xact({8'h01, 8'h10, 8'h01, 8'h00, 8'h00, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00},
            {8'h01, 8'h90, 8'h03});
        xact({8'h01, 8'h10, 8'h02, 8'h00, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34},
            {8'h01, 8'h90, 8'h02});
        // input registers are read-only, so a write there is unmapped
        xact({8'h01, 8'h10, 8'h00, 8'h97, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34},
            {8'h01, 8'h90, 8'h02});
    endtask
    task automatic t_coils();
        logic [7:0] a[3] = '{8'h7f, 8'h80, 8'h85};
        int w, d, b;
        for (int k = 0; k < 3; k++)
        begin
            w = n_web;
            d = n_id;
            b = n_boot;
            xact({8'h01, 8'h05, 8'h00, a[k], 8'hff, 8'h00},
                {8'h01, 8'h05, 8'h00, a[k], 8'hff, 8'h00});
            check("pulses", 3'b100 >> k, {n_web - w == 1, n_id - d == 1,
                n_boot - b == 1});
        end
    endtask
    task automatic t_inputs();
        logic [7:0] a[3] = '{8'h97, 8'h9e, 8'ha0};
        logic [15:0] v[3] = '{FW, 16'h0001, 16'h0002};
        @(negedge sys_clk);
        comm_to = 1'b1;
        pair = 2'h2;
        for (int k = 0; k < 3; k++)
            xact({8'h01, 8'h04, 8'h00, a[k], 8'h00, 8'h01},
                {8'h01, 8'h04, 8'h02, v[k][15:8], v[k][7:0]});
        xact({8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h08},
            {8'h01, 8'h02, 8'h01, din});
    endtask
    task automatic t_misc();
        xact({8'h01, 8'h05, 8'h00, 8'h03, 8'hff, 8'h00},
            {8'h01, 8'h05, 8'h00, 8'h03, 8'hff, 8'h00});
        check("coils", 32'h08, coils);
        xact({8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h08}, {8'h01, 8'h01, 8'h01, 8'h08});
        // function code alone, no data field behind it
        xact({8'h01, 8'h2b}, {8'h01, 8'hab, 8'h01});
        // another station's frame is swallowed without an answer
        m_u.q = {8'h00, 8'h00, 8'h00, 8'h09, 8'h00, 8'h06,
            8'h02, 8'h03, 8'h01, 8'h00, 8'h00, 8'h01};
        m_u.rsp = {};
        m_u.send();
        repeat (40) @(negedge sys_clk);
        check("other_rsp", 0, m_u.rsp.size());
        check("other_rdy", 1, rx_ready);
    endtask
    initial
    begin
        repeat (16) @(negedge sys_clk);
        resetn = 1'b1;
        t_write();
        t_errors();
        t_coils();
        t_inputs();
        t_misc();
        complete_run();
    end
endmodule // modbus_tcp_write_regs_and_common_map_tb_top
